// file: dac_ctl_consts.svh
/*
 * constants for the four-channel converter update and reset control:
 * command codes, frame field positions, reset values and timing counts.
 * assumes it is included by bare name wherever a figure is needed.
 */
`ifndef DAC_CTL_CONSTS_SVH
`define DAC_CTL_CONSTS_SVH

`define CH_COUNT 4
`define CODE_W 10
`define FRAME_W 24
`define CMD_HI 23
`define CMD_LO 20
`define ADDR_HI 19
`define ADDR_LO 16
`define DATA_HI 15
`define DATA_LO 6
`define CMD_WR_INPUT 4'h1
`define CMD_UPD_DAC 4'h2
`define CMD_WR_UPD 4'h3
`define CMD_LOAD_MASK 4'h5
`define CMD_SOFT_RST 4'h6
`define CMD_REF_SETUP 4'h7
`define MASK_RST 4'h0
`define REF_RST 1'b0
`define ZERO_CODE 10'h000
`define MID_CODE 10'h200
`define CLR_MIN_NS 30
`define MCLK_NS 50
`define CLR_MIN_CYC ((`CLR_MIN_NS + `MCLK_NS - 1) / `MCLK_NS)
`define POR_NS 1000
`define POR_CYC (`POR_NS / `MCLK_NS)

`endif

// file: dac_ctl_pkg.sv
/*
 * types shared by the converter control files.
 * assumes dac_ctl_consts.svh is available on the include path.
 */
`include "dac_ctl_consts.svh"
package dac_ctl_pkg;
	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] addr;
		logic [15:0] data;
	} frame_t;
	typedef enum logic [1:0] {
		ST_POR,
		ST_WAIT_CLR,
		ST_RUN
	} init_state_t;
endpackage

// file: level_sync.sv
/*
 * two flip-flop synchroniser for a level from a pin or another clock.
 * assumes the destination clock is the one given on clk.
 */
module level_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// level in and out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= INIT;
			q <= INIT;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// file: frame_cross.sv
/*
 * carries a finished 24-bit frame from the link clock to mclk by a toggle
 * handshake. the word is held stable in the link domain until mclk has
 * seen the toggle, so the receiver may sample it freely.
 * assumes frames arrive no faster than one per four link clocks.
 */
module frame_cross
	import dac_ctl_pkg::*;
(
	// link side
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic frame_valid,
	input wire frame_t frame_in,
	// core side
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	output frame_t frame_out,
	output logic frame_stb
);
	logic tog_r;
	frame_t hold_r;
	logic tog_s;
	logic tog_d_r;

	// capture the word and flip the toggle in the link domain
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			tog_r <= 1'b0;
			hold_r <= '0;
		end else if (frame_valid) begin
			tog_r <= ~tog_r;
			hold_r <= frame_in;
		end
	end

	level_sync #(.W(1), .INIT(1'b0)) u_tog (
		.clk(mclk),
		.rst(rst),
		.ce(ce),
		.d(tog_r),
		.q(tog_s)
	);

	// a change of the synchronised toggle marks one new frame
	always_ff @(posedge mclk) begin
		if (rst) begin
			tog_d_r <= 1'b0;
			frame_out <= '0;
			frame_stb <= 1'b0;
		end else if (ce) begin
			tog_d_r <= tog_s;
			frame_stb <= tog_s ^ tog_d_r;
			if (tog_s ^ tog_d_r) begin
				frame_out <= hold_r;
			end
		end
	end
endmodule

// file: dac_update_ctl.sv
/*
 * update, clear and reference control of a four-channel converter with
 * input and output registers per channel. frames come from the serial
 * front end on link_clk; everything else runs on mclk.
 * assumes the front end delivers one frame_valid pulse per complete
 * 24-bit write and that the pins are asynchronous to mclk.
 */
`include "dac_ctl_consts.svh"

// Overview of operation
// - command 0001 with strobe high writes input only; strobe fall loads unmasked channels
// - command 0101 loads the 4-bit mask from bits 3..0, address ignored
// - mask bit 3 is channel D down to bit 0 channel A
// - mask bits reset to zero so all channels follow the strobe
// - a masked channel ignores strobe falling edges, but not the strobe low level
// - each strobe falling edge copies input to output on unmasked channels; with a 0001 or 0011 frame in that cycle they take its code
// - strobe tied low ignores the mask; 0001 updates input and output
// - 0001 writes the input register unless clear is low; output unchanged while strobe high
// - 0010 copies input register to output register, input unchanged
// - 0011 writes input and output registers whatever the strobe level
// - clear pin low sets outputs to zero or midscale; held at least 30 ns
// - no updates while clear is low; cleared value holds after release
// - 0110 returns the converter to its power-on code
// - strobe activity during power-on reset is ignored
// - clear held low at power-up stalls initialisation until release
// - power-up level set by the select pin, held until the first write
// - 0111 loads reference setup from bit 0; one turns the reference off
// - frame carries command in bits 23..20, address 19..16, then data
// - with strobe low, 0001 updates input and output at the frame end
module dac_update_ctl
	import dac_ctl_pkg::*;
#(
	parameter int CH = `CH_COUNT,
	parameter int CW = `CODE_W,
	parameter int POR_CYCLES = `POR_CYC
) (
	// core clock and control
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// link side frames
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic frame_valid,
	input wire frame_t frame_in,
	// pins
	input wire logic load_strobe_n,
	input wire logic clear_n,
	input wire logic clear_level_select,
	// converter side
	output logic [CH*CW-1:0] dac_code,
	output logic reference_off,
	output logic init_done
);
	frame_t frm;
	logic frm_stb;
	logic ld_s;
	logic clr_s_n;
	logic sel_s;
	logic ld_d_r;
	init_state_t st_r;
	init_state_t st_nxt;
	logic [15:0] por_cnt_r;
	logic [3:0] load_mask_r;
	logic reference_setup_r;
	logic [CW-1:0] clr_code_r;
	logic [CW-1:0] inreg_r [CH];
	logic [CW-1:0] dacreg_r [CH];

	frame_cross u_cross (
		.link_clk(link_clk),
		.link_rst(link_rst),
		.frame_valid(frame_valid),
		.frame_in(frame_in),
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.frame_out(frm),
		.frame_stb(frm_stb)
	);

	// strobe idles high, clear idles released
	level_sync #(.W(3), .INIT(3'b110)) u_pins (
		.clk(mclk),
		.rst(rst),
		.ce(ce),
		.d({load_strobe_n, clear_n, clear_level_select}),
		.q({ld_s, clr_s_n, sel_s})
	);

	// decode of the received frame
	wire running = (st_r == ST_RUN);
	wire clr_act = ~clr_s_n;
	wire ld_fall = ld_d_r & ~ld_s;
	wire [3:0] f_cmd = frm.cmd;
	wire [3:0] f_addr = frm.addr;
	// the code field sits left-justified in the data word, low bits unused
	wire [CW-1:0] f_code = frm.data[`DATA_HI:`DATA_LO];
	wire cmd_ok = frm_stb & running & ~clr_act;
	wire do_wr_in = cmd_ok & (f_cmd == `CMD_WR_INPUT);
	wire do_upd = cmd_ok & (f_cmd == `CMD_UPD_DAC);
	wire do_wr_upd = cmd_ok & (f_cmd == `CMD_WR_UPD);
	wire do_mask = cmd_ok & (f_cmd == `CMD_LOAD_MASK);
	wire do_soft_rst = cmd_ok & (f_cmd == `CMD_SOFT_RST);
	wire do_ref = cmd_ok & (f_cmd == `CMD_REF_SETUP);
	wire [CW-1:0] sel_code = sel_s ? `MID_CODE : `ZERO_CODE;
	// the strobe counts only once running; edges during power-on are dropped
	wire ld_evt = ld_fall & running & ~clr_act;

	// power-on sequence: count out the reset, then wait for clear release
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_POR: begin
				if (por_cnt_r >= 16'(POR_CYCLES - 1)) begin
					st_nxt = ST_WAIT_CLR;
				end
			end
			ST_WAIT_CLR: begin
				if (clr_s_n) begin
					st_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (do_soft_rst) begin
					st_nxt = ST_POR;
				end
			end
			default: st_nxt = ST_POR;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= ST_POR;
			por_cnt_r <= 16'h0000;
			ld_d_r <= 1'b1;
		end else if (ce) begin
			st_r <= st_nxt;
			por_cnt_r <= (st_r == ST_POR) ? por_cnt_r + 16'h0001 : 16'h0000;
			ld_d_r <= ld_s;
		end
	end

	// mask and reference setup registers, write-only from frames
	always_ff @(posedge mclk) begin
		if (rst) begin
			load_mask_r <= `MASK_RST;
			reference_setup_r <= `REF_RST;
		end else if (ce) begin
			if (do_soft_rst) begin
				load_mask_r <= `MASK_RST;
				reference_setup_r <= `REF_RST;
			end else begin
				if (do_mask) begin
					load_mask_r <= frm.data[3:0];
				end
				if (do_ref) begin
					reference_setup_r <= frm.data[0];
				end
			end
		end
	end

	// the power-up level is caught from the select pin while not running
	always_ff @(posedge mclk) begin
		if (rst) begin
			clr_code_r <= `ZERO_CODE;
		end else if (ce && (!running || clr_act)) begin
			clr_code_r <= sel_code;
		end
	end

	// per channel input and output registers
	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : g_ch
			wire hit = (f_addr[g] == 1'b1);
			// masked channel sees a high strobe; the level test covers a tied-low pin
			wire strobe_low = ~ld_s & ~load_mask_r[g];
			wire tied_low = ~ld_s;
			wire wr_in = (do_wr_in | do_wr_upd) & hit;
			wire ld_out = (ld_evt & ~load_mask_r[g])
				| (do_upd & hit)
				| (do_wr_in & hit & tied_low)
				| (do_wr_upd & hit);
			wire [CW-1:0] out_src = (do_wr_in | do_wr_upd) ? f_code : inreg_r[g];

			always_ff @(posedge mclk) begin
				if (rst) begin
					inreg_r[g] <= `ZERO_CODE;
					dacreg_r[g] <= `ZERO_CODE;
				end else if (ce) begin
					if (!running || clr_act) begin
						// cleared level held through power-on and clear
						inreg_r[g] <= sel_code;
						dacreg_r[g] <= sel_code;
					end else begin
						if (wr_in) begin
							inreg_r[g] <= f_code;
						end
						if (ld_out) begin
							dacreg_r[g] <= out_src;
						end
					end
				end
			end

			assign dac_code[g*CW +: CW] = dacreg_r[g];

			// output moves only for a frame or a strobe fall
			chg_cause_a: assert property (@(posedge mclk) disable iff (rst)
				(ce && running && $past(running) && !clr_act && $changed(dacreg_r[g]))
				|-> ($past(frm_stb) || $past(ld_evt)))
				else $error("output changed without a cause");
			// masked channel ignores the strobe
			mask_block_a: assert property (@(posedge mclk) disable iff (rst)
				(ce && ld_evt && load_mask_r[g] && !frm_stb) |=> $stable(dacreg_r[g]))
				else $error("masked channel followed the strobe");
			// unmasked channel takes the input register on a strobe fall
			strobe_load_a: assert property (@(posedge mclk) disable iff (rst)
				(ce && ld_evt && !load_mask_r[g] && !frm_stb)
				|=> (dacreg_r[g] == $past(inreg_r[g])))
				else $error("strobe fall did not load channel");
			// write with strobe high keeps the output
			defer_wr_a: assert property (@(posedge mclk) disable iff (rst)
				(ce && do_wr_in && hit && ld_s && !ld_evt) |=> $stable(dacreg_r[g]))
				else $error("deferred write changed output");
			// update command leaves the input register alone
			upd_keep_a: assert property (@(posedge mclk) disable iff (rst)
				(ce && do_upd && hit) |=> (dacreg_r[g] == $past(inreg_r[g])
				&& $stable(inreg_r[g])))
				else $error("update command misbehaved");
			// write and update sets both registers
			wr_both_a: assert property (@(posedge mclk) disable iff (rst)
				(ce && do_wr_upd && hit) |=> (inreg_r[g] == $past(f_code)
				&& dacreg_r[g] == $past(f_code)))
				else $error("write and update missed a register");
			// strobe held low makes a plain write reach the output
			tied_wr_a: assert property (@(posedge mclk) disable iff (rst)
				(ce && do_wr_in && hit && !ld_s) |=> (dacreg_r[g] == $past(f_code)))
				else $error("write with strobe low missed output");
			// clear forces the selected level within two cycles
			clear_level_a: assert property (@(posedge mclk) disable iff (rst)
				(ce && clr_act) [*2] |-> (dacreg_r[g] == $past(sel_code)))
				else $error("clear did not set the level");
		end
	endgenerate

	assign reference_off = reference_setup_r;
	assign init_done = running;

	// mask write takes bits 3..0 whatever the address
	mask_load_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && do_mask) |=> (load_mask_r == $past(frm.data[3:0])))
		else $error("mask not loaded");
	// reference bit follows bit 0 of its frame
	ref_load_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && do_ref) |=> (reference_off == $past(frm.data[0])))
		else $error("reference setup not loaded");
	// soft reset returns to power-on and clears the mask
	soft_rst_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && do_soft_rst) |=> (st_r == ST_POR && load_mask_r == 4'h0))
		else $error("soft reset not taken");
	// no start while the clear pin is low
	clr_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_WAIT_CLR && !clr_s_n) |=> (st_r != ST_RUN))
		else $error("started with clear low");
	// strobe ignored while not running
	por_ignore_a: assert property (@(posedge mclk) disable iff (rst)
		(!running) |-> !ld_evt)
		else $error("strobe acted during power-on");
endmodule

// file: frame_master.sv
/*
 * far-side model: the serial master that hands complete 24-bit frames to
 * the control block on its own link clock.
 * assumes the caller spaces calls to send; the clock only runs during link reset and frames.
 */
module frame_master
	import dac_ctl_pkg::*;
(
	// link outputs
	output logic link_clk,
	output logic link_rst,
	output logic frame_valid,
	output frame_t frame_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		link_clk = 1'b0;
		link_rst = 1'b1;
		frame_valid = 1'b0;
		frame_in = '0;
	end
	// clock stands still between frames, as a real master leaves it
	task automatic tick(input int n);
		repeat (n) begin
			#80 link_clk = 1'b1;
			#80 link_clk = 1'b0;
		end
	endtask
	task automatic reset_link();
		link_rst = 1'b1;
		tick(2);
		link_rst = 1'b0;
		tick(2);
	endtask
	// odd offset keeps link edges off the mclk grid
	task automatic send(input frame_t f);
		#13;
		frame_in = f;
		frame_valid = 1'b1;
		tick(1);
		frame_valid = 1'b0;
		frame_in = ~f; // stale word is not left on the lines
		tick(4); // frames at least four link clocks apart
	endtask
endmodule

// file: quad_dac_update_reset_control_bench.sv
/*
 * self-checking bench of the converter update and clear control.
 * assumes frame_master supplies the link domain and POR_CYCLES is 4.
 */
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module quad_dac_update_reset_control_bench
	import dac_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [39:0] code; logic ref_off; logic init;} obs_t;
	logic mclk, rst, ce, link_clk, link_rst, frame_valid;
	logic load_strobe_n, clear_n, clear_level_select, reference_off, init_done, look;
	frame_t frame_in;
	logic [39:0] dac_code;
	logic [9:0] inp [4];
	logic [9:0] dac [4];
	logic [3:0] mask;
	logic ref_e;
	obs_t q [$];
	obs_t e;
	int fails = 0;
	int n_tests = 0;
	int seed = 66;

	frame_master fm (.link_clk(link_clk), .link_rst(link_rst),
		.frame_valid(frame_valid), .frame_in(frame_in));
	dac_update_ctl #(.POR_CYCLES(4)) dut_u (.mclk(mclk), .rst(rst), .ce(ce),
		.link_clk(link_clk), .link_rst(link_rst), .frame_valid(frame_valid),
		.frame_in(frame_in), .load_strobe_n(load_strobe_n), .clear_n(clear_n),
		.clear_level_select(clear_level_select), .dac_code(dac_code),
		.reference_off(reference_off), .init_done(init_done));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	// driver notes the expected state; the monitor compares one cycle on
	task automatic note(input logic init);
		q.push_back({dac[3], dac[2], dac[1], dac[0], ref_e, init});
		look = 1'b1;
		cyc(1);
		look = 1'b0;
	endtask
	always @(posedge mclk) begin
		if (look) begin
			e = q.pop_front();
			`CHK({dac_code, reference_off, init_done}, e)
		end
	end
	task automatic por_code();
		for (int i = 0; i < 4; i++) dac[i] = clear_level_select ? 10'h200 : 10'h000;
	endtask
	// one frame, with the bench model following the command table
	task automatic wr(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
		fm.send({c, a, d});
		for (int i = 0; i < 4; i++) begin
			if (a[i] && (c == 4'h1 || c == 4'h3)) inp[i] = d[15:6];
			if (a[i] && (c == 4'h3 || (c == 4'h1 && !load_strobe_n))) dac[i] = d[15:6];
			if (a[i] && c == 4'h2) dac[i] = inp[i];
		end
		if (c == 4'h5) mask = d[3:0];
		if (c == 4'h7) ref_e = d[0];
		if (c == 4'h6) begin
			por_code();
			mask = 4'h0;
			ref_e = 1'b0;
			cyc(20);
		end
		cyc(4);
	endtask
	task automatic fill();
		for (int i = 0; i < 4; i++) wr(4'h1, 4'h1 << i, 16'($random(seed)));
	endtask
	task automatic fall(input logic stay_low);
		load_strobe_n = 1'b0;
		for (int i = 0; i < 4; i++) if (!mask[i]) dac[i] = inp[i];
		cyc(4);
		load_strobe_n = stay_low ? 1'b0 : 1'b1;
		cyc(4);
	endtask
	task automatic test_done();
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#1ms;
		fails++;
		test_done();
	end

	initial begin
		{rst, ce, load_strobe_n, clear_level_select, look, ref_e} = 6'b111100;
		clear_n = 1'b0;
		mask = 4'h0;
		por_code();
		// strobe wiggled during reset must leave nothing behind
		fork
			fm.reset_link();
			begin
				cyc(3);
				load_strobe_n = 1'b0;
				cyc(2);
				load_strobe_n = 1'b1;
				cyc(3);
				rst = 1'b0;
			end
		join
		cyc(20);
		note(1'b0);
		clear_n = 1'b1;
		cyc(10);
		note(1'b1);
		fill();
		note(1'b1);
		fall(1'b0);
		note(1'b1);
		repeat (3) begin
			wr(4'h5, 4'($random(seed)), 16'($random(seed)));
			fill();
			fall(1'b0);
			note(1'b1);
		end
		wr(4'h2, 4'hf, 16'($random(seed)));
		note(1'b1);
		wr(4'h3, 4'h4, 16'($random(seed)));
		note(1'b1);
		wr(4'h5, 4'h0, 16'h0002);
		fall(1'b1);
		wr(4'h1, 4'h2, 16'($random(seed)));
		note(1'b1);
		load_strobe_n = 1'b1;
		wr(4'h7, 4'h0, 16'h0001);
		note(1'b1);
		wr(4'h7, 4'h0, 16'hfffe);
		note(1'b1);
		// a frame sent while clear is low is refused
		clear_level_select = 1'b0;
		clear_n = 1'b0;
		fm.send({4'h3, 4'h1, 16'hffc0});
		cyc(4);
		por_code();
		note(1'b1);
		clear_n = 1'b1;
		cyc(6);
		note(1'b1);
		clear_level_select = 1'b1;
		wr(4'h5, 4'h0, 16'h000f);
		wr(4'h7, 4'h0, 16'h0001);
		wr(4'h6, 4'h0, 16'h0000);
		note(1'b1);
		fill();
		fall(1'b0);
		note(1'b1);
		test_done();
	end
endmodule
